// File: hw/eeprom_status_regs.svh
// bit positions, reset values and timing figures of the status register pair
`ifndef EEPROM_STATUS_REGS_SVH
`define EEPROM_STATUS_REGS_SVH

// low status byte
`define LOW_PIN_PROTECT_BIT   7
`define LOW_BLOCK_HI_BIT      3
`define LOW_BLOCK_LO_BIT      2
`define LOW_WEL_BIT           1
`define LOW_BUSY_BIT          0

// high status byte
`define HIGH_MODE_BIT         7
`define HIGH_ECC_BIT          6
`define HIGH_FROZEN_BIT       5
`define HIGH_PREL_BIT         4
`define HIGH_BOUNDARY_BIT     3
`define HIGH_BUSY_BIT         0

// power-on values of the nonvolatile bits
`define RST_PIN_PROTECT       1'b0
`define RST_BLOCK_LEVEL       2'h0
`define RST_MODE_SELECT       1'b1
`define RST_FROZEN            1'b0
`define RST_BOUNDARY          1'b0

// self-timed write cycle
`define WRITE_CYCLE_NS        5000000
`define CLK_PERIOD_NS         50
`define WRITE_CYCLES          (`WRITE_CYCLE_NS / `CLK_PERIOD_NS)
`define TIMER_W               17

`endif

// File: hw/eeprom_status_pkg.sv
// types of the status register bank
`include "eeprom_status_regs.svh"

package eeprom_status_pkg;

   typedef enum logic [1:0] {
      OP_STATUS   = 2'b00,
      OP_FREEZE   = 2'b01,
      OP_BOUNDARY = 2'b10,
      OP_ARRAY    = 2'b11
   } nv_op_t;

   typedef struct packed {
      logic                  cs_s1;
      logic                  cs_s2;
      logic                  wp_s1;
      logic                  wp_s2;
      logic                  frame_wp_low;
      logic                  pin_protect_enable;
      logic [1:0]            block_protect_level;
      logic                  protection_mode_select;
      logic                  config_frozen_flag;
      logic                  boundary_locked;
      logic                  write_enable_latch;
      logic                  partition_release;
      logic                  ecc_used_flag;
      logic                  busy;
      nv_op_t                op;
      logic                  pend_pin_protect;
      logic [1:0]            pend_block_level;
      logic                  pend_mode;
      logic [`TIMER_W-1:0]   timer;
   } state_t;

endpackage

// File: hw/eeprom_status_register.sv
// status register bank of a serial eeprom with hardware write protection
`timescale 1ns/1ns
`include "eeprom_status_regs.svh"

// Notes on behaviour
// - status is two bytes: six nonvolatile bits plus four volatile latches.
// - bits are read or changed only through dedicated serial instruction strobes.
// - low byte bit 7 enables the write-protect pin; clear means pin ignored.
// - low bits 6..4 and high bits 2..1 always read zero.
// - low bits 3..2 pick protection: none, upper quarter, upper half, all.
// - low bit 1 reads one after write enable, zero otherwise.
// - low bit 0 reads one during a self-timed write cycle.
// - hardware protection only when pin low and pin-protect enable set.
// - the protection mode bit, high byte bit 7, decides what is blocked.
// - mode bit zero selects legacy blocks, one selects partition protection.
// - high bit 5 freezes configuration, defaults zero, once set clears only on reset.
// - high bit 6 reads one only if the last read needed error correction.
// - ready/busy is mirrored at bit 0 of both bytes.
module eeprom_status_register #(
   parameter int unsigned WRITE_CYCLES = `WRITE_CYCLES
) (
   input  wire logic       clk,
   input  wire logic       reset,
   input  wire logic       wp_n_pin,
   input  wire logic       cs_n_pin,
   input  wire logic       write_enable_cmd,
   input  wire logic       write_disable_cmd,
   input  wire logic       status_write_cmd,
   input  wire logic [7:0] status_write_low,
   input  wire logic [7:0] status_write_high,
   input  wire logic       freeze_cmd,
   input  wire logic       partition_release_cmd,
   input  wire logic       boundary_protect_cmd,
   input  wire logic       array_write_cmd,
   input  wire logic       read_done,
   input  wire logic       read_ecc_used,
   input  wire logic       soft_reset_cmd,
   output logic [7:0]      status_low_byte,
   output logic [7:0]      status_high_byte,
   output logic            hw_protected,
   output logic [1:0]      array_protect_level,
   output logic            enhanced_mode,
   output logic            boundary_locked
);

   localparam eeprom_status_pkg::state_t RESET_STATE = '{
      cs_s1: 1'b1, cs_s2: 1'b1, wp_s1: 1'b1, wp_s2: 1'b1, frame_wp_low: 1'b0,
      pin_protect_enable: `RST_PIN_PROTECT, block_protect_level: `RST_BLOCK_LEVEL,
      protection_mode_select: `RST_MODE_SELECT, config_frozen_flag: `RST_FROZEN,
      boundary_locked: `RST_BOUNDARY, write_enable_latch: 1'b0,
      partition_release: 1'b0, ecc_used_flag: 1'b0, busy: 1'b0,
      op: eeprom_status_pkg::OP_STATUS, pend_pin_protect: 1'b0,
      pend_block_level: 2'h0, pend_mode: 1'b0, timer: '0};

   eeprom_status_pkg::state_t state_q;
   eeprom_status_pkg::state_t state_d;

   logic wp_low;
   logic ready;
   logic write_enable_cmd_ok;
   logic wrdi_ok;
   logic wrsr_ok;
   logic frz_ok;
   logic prel_ok;
   logic ppab_ok;
   logic arr_ok;
   logic start_ok;

   // ----------------------------------------------------------------------
   // protection and command acceptance
   // ----------------------------------------------------------------------
   assign wp_low       = !state_q.wp_s2;
   assign ready        = !state_q.busy;
   // the pin must stay low for the whole select time to protect
   assign hw_protected = state_q.pin_protect_enable & state_q.frame_wp_low & wp_low;

   // every change arrives as an instruction strobe from the serial decoder
   assign write_enable_cmd_ok = write_enable_cmd & ready;
   assign wrdi_ok = write_disable_cmd & ready;
   assign wrsr_ok = status_write_cmd & ready & state_q.write_enable_latch & !hw_protected;
   assign frz_ok  = freeze_cmd & ready & state_q.write_enable_latch & state_q.partition_release
                    & !hw_protected & !state_q.config_frozen_flag;
   assign prel_ok = partition_release_cmd & ready & state_q.write_enable_latch;
   assign ppab_ok = boundary_protect_cmd & ready & state_q.write_enable_latch
                    & state_q.partition_release & !hw_protected;
   assign arr_ok  = array_write_cmd & ready & state_q.write_enable_latch;
   assign start_ok = wrsr_ok | frz_ok | ppab_ok | arr_ok;

   // ----------------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------------
   always_comb begin
      state_d = state_q;
      state_d.cs_s1 = cs_n_pin;
      state_d.cs_s2 = state_q.cs_s1;
      state_d.wp_s1 = wp_n_pin;
      state_d.wp_s2 = state_q.wp_s1;
      state_d.frame_wp_low = state_q.cs_s2 ? wp_low : (state_q.frame_wp_low & wp_low);

      // write enable wins when both strobes arrive together
      if (wrdi_ok) begin
         state_d.write_enable_latch = 1'b0;
      end
      if (write_enable_cmd_ok) begin
         state_d.write_enable_latch = 1'b1;
      end
      if (prel_ok) begin
         state_d.partition_release = 1'b1;
      end

      // nonvolatile bits change only when the write cycle completes
      if (start_ok) begin
         state_d.busy  = 1'b1;
         state_d.timer = `TIMER_W'(WRITE_CYCLES - 1);
         if (wrsr_ok) begin
            state_d.op = eeprom_status_pkg::OP_STATUS;
         end else if (frz_ok) begin
            state_d.op = eeprom_status_pkg::OP_FREEZE;
         end else if (ppab_ok) begin
            state_d.op = eeprom_status_pkg::OP_BOUNDARY;
         end else begin
            state_d.op = eeprom_status_pkg::OP_ARRAY;
         end
         // only the enable and block bits are taken from the low byte
         state_d.pend_pin_protect = status_write_low[`LOW_PIN_PROTECT_BIT];
         state_d.pend_block_level = status_write_low[`LOW_BLOCK_HI_BIT:`LOW_BLOCK_LO_BIT];
         state_d.pend_mode        = state_q.config_frozen_flag ? state_q.protection_mode_select
                                    : status_write_high[`HIGH_MODE_BIT];
      end else if (state_q.busy) begin
         if (state_q.timer == '0) begin
            unique case (state_q.op)
               eeprom_status_pkg::OP_STATUS: begin
                  state_d.pin_protect_enable     = state_q.pend_pin_protect;
                  state_d.block_protect_level    = state_q.pend_block_level;
                  state_d.protection_mode_select = state_q.pend_mode;
               end
               eeprom_status_pkg::OP_FREEZE: begin
                  state_d.config_frozen_flag = 1'b1;
                  state_d.partition_release  = 1'b0;
               end
               eeprom_status_pkg::OP_BOUNDARY: begin
                  state_d.boundary_locked   = 1'b1;
                  state_d.partition_release = 1'b0;
               end
               eeprom_status_pkg::OP_ARRAY: begin
                  state_d.busy = 1'b0;
               end
            endcase
            state_d.busy = 1'b0;
            state_d.write_enable_latch = 1'b0;
         end else begin
            state_d.timer = state_q.timer - `TIMER_W'(1);
         end
      end

      if (read_done & ready) begin
         state_d.ecc_used_flag = read_ecc_used;
      end
      // soft reset wins over a read that ends in the same cycle
      if (soft_reset_cmd & ready) begin
         state_d.write_enable_latch = 1'b0;
         state_d.partition_release  = 1'b0;
         state_d.ecc_used_flag      = 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         state_q <= RESET_STATE;
      end else begin
         state_q <= state_d;
      end
   end

   // ----------------------------------------------------------------------
   // read-back and protection outputs
   // ----------------------------------------------------------------------
   // six nonvolatile bits and four volatile latches across two bytes
   assign status_low_byte = {state_q.pin_protect_enable, 3'h0,
                             state_q.block_protect_level,
                             state_q.write_enable_latch, state_q.busy};
   assign status_high_byte = {state_q.protection_mode_select, state_q.ecc_used_flag,
                              state_q.config_frozen_flag, state_q.partition_release,
                              state_q.boundary_locked, 2'h0, state_q.busy};

   // block levels act only in legacy mode
   assign array_protect_level = state_q.protection_mode_select ? 2'h0
                                : state_q.block_protect_level;
   assign enhanced_mode       = state_q.protection_mode_select;
   assign boundary_locked     = state_q.boundary_locked;

   // ----------------------------------------------------------------------
   // checks: read-back layout
   // ----------------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   chk_unused_zero: assert property (
      status_low_byte[6:4] == 3'h0 && status_high_byte[2:1] == 2'h0)
      else $error("unused status bits not zero");
   chk_busy_mirror: assert property (
      status_low_byte[0] == status_high_byte[0])
      else $error("busy mirror mismatch");
   chk_mode_levels: assert property (
      array_protect_level == (status_high_byte[7] ? 2'h0 : status_low_byte[3:2]))
      else $error("block level wrong for mode");

   // ----------------------------------------------------------------------
   // checks: write sequencing
   // ----------------------------------------------------------------------
   chk_wel_set: assert property (
      write_enable_cmd && !status_low_byte[0] |=> status_low_byte[1])
      else $error("write enable not latched");
   chk_wel_clear: assert property (
      write_disable_cmd && !write_enable_cmd && !status_low_byte[0]
      |=> !status_low_byte[1])
      else $error("write disable left latch set");
   chk_wel_needs_cmd: assert property (
      $rose(status_low_byte[1]) |-> $past(write_enable_cmd))
      else $error("write enable set without its instruction");
   chk_write_busy: assert property (
      status_write_cmd && status_low_byte[1:0] == 2'b10 && !hw_protected
      |=> status_low_byte[0] && status_high_byte[0])
      else $error("write cycle not flagged busy");
   chk_array_busy: assert property (
      array_write_cmd && status_low_byte[1:0] == 2'b10
      |=> status_low_byte[0])
      else $error("array write cycle not flagged busy");
   chk_busy_start: assert property (
      $rose(status_low_byte[0])
      |-> $past(status_write_cmd) || $past(freeze_cmd) || $past(boundary_protect_cmd)
          || $past(array_write_cmd))
      else $error("write cycle began without a start strobe");
   chk_done_clears: assert property (
      status_low_byte[0] ##1 !status_low_byte[0]
      |-> !status_low_byte[1])
      else $error("write enable left set after write cycle");
   chk_nv_steady: assert property (
      status_low_byte[0] ##1 status_low_byte[0]
      |-> $stable(status_low_byte[7:2]) && $stable(status_high_byte[7:1]))
      else $error("status bits moved during write cycle");
   chk_nv_at_done: assert property (
      $changed(status_low_byte[7:2]) || $changed(status_high_byte[7])
      |-> $fell(status_low_byte[0]))
      else $error("protection bits changed outside a write cycle end");
   chk_wsr_keeps_wel: assert property (
      status_write_cmd && status_low_byte[1:0] == 2'b10 && !hw_protected
      |=> status_low_byte[1])
      else $error("status write changed write enable");
   chk_wel_hold: assert property (
      status_low_byte[1:0] == 2'b11 && !soft_reset_cmd
      |-> ##1 status_low_byte[1] || !$past(status_low_byte[0]) || !status_low_byte[0])
      else $error("write enable dropped during cycle");

   // ----------------------------------------------------------------------
   // checks: hardware protection
   // ----------------------------------------------------------------------
   chk_protect_blocks: assert property (
      status_write_cmd && hw_protected && !status_low_byte[0]
      |=> !status_low_byte[0] && $stable(status_low_byte[7:2]))
      else $error("protected status write accepted");
   chk_pin_ignored: assert property (
      status_write_cmd && !status_low_byte[7] && status_low_byte[1:0] == 2'b10
      |=> status_low_byte[0])
      else $error("pin blocked write with enable clear");
   chk_protect_needs_en: assert property (
      hw_protected |-> status_low_byte[7])
      else $error("protection without pin enable");
   chk_freeze_blocked: assert property (
      freeze_cmd && hw_protected && !status_low_byte[0] && !status_write_cmd
      && !boundary_protect_cmd && !array_write_cmd |=> !status_low_byte[0])
      else $error("protected freeze accepted");

   // ----------------------------------------------------------------------
   // checks: freeze and error flag
   // ----------------------------------------------------------------------
   chk_frozen_sticky: assert property (
      status_high_byte[5] |=> status_high_byte[5])
      else $error("frozen flag cleared");
   chk_mode_frozen: assert property (
      $past(status_high_byte[5]) |-> $stable(status_high_byte[7]))
      else $error("mode bit changed while frozen");
   chk_freeze_done: assert property (
      $rose(status_high_byte[5]) |-> !status_high_byte[4] && !status_low_byte[1])
      else $error("freeze left release or enable latch set");
   chk_ecc_flag: assert property (
      read_done && !status_low_byte[0] && !soft_reset_cmd
      |=> status_high_byte[6] == $past(read_ecc_used))
      else $error("ecc flag not from last read");
   chk_ecc_soft_clear: assert property (
      soft_reset_cmd && !status_low_byte[0] |=> !status_high_byte[6])
      else $error("soft reset left ecc flag set");
   chk_ecc_hold: assert property (
      !read_done && !soft_reset_cmd |=> $stable(status_high_byte[6]))
      else $error("ecc flag changed without a read");

   // ----------------------------------------------------------------------
   // coverage
   // ----------------------------------------------------------------------
   cov_status_commit: cover property (status_low_byte[0] ##1 !status_low_byte[0]);
   cov_freeze: cover property ($rose(status_high_byte[5]));
   cov_protected: cover property (status_write_cmd && hw_protected);
   cov_ecc_set: cover property ($rose(status_high_byte[6]));
   cov_boundary: cover property ($rose(boundary_locked));

endmodule // eeprom_status_register

// File: verification/status_host_model.sv
// host-side model issuing status instructions inside chip-select frames
`timescale 1ns/1ns
module status_host_model (
   input  wire logic  clk,
   input  wire logic  hw_protected,
   output logic       cs_n_pin,
   output logic       wp_n_pin,
   output logic [8:0] strobes,
   output logic [7:0] wr_low,
   output logic [7:0] wr_high,
   output logic       ecc_used
);
   logic prot_seen;

   initial begin
      cs_n_pin = 1'b1;
      wp_n_pin = 1'b1;
      strobes = 9'h000;
      wr_low = 8'h00;
      wr_high = 8'h00;
      ecc_used = 1'b0;
      prot_seen = 1'b0;
   end

   // ------------------------------------------------------------
   // one frame: select, sixteen clock periods of shifting, decode
   // ------------------------------------------------------------
   task automatic frame(input logic [8:0] s, input logic [7:0] lo,
                        input logic [7:0] hi, input logic ecc);
      @(posedge clk);
      #2 cs_n_pin = 1'b0;
      repeat (16) @(posedge clk);
      #2 prot_seen = hw_protected;
      strobes = s;
      wr_low = lo;
      wr_high = hi;
      ecc_used = ecc;
      @(posedge clk);
      #2 strobes = 9'h000;
      wr_low = ~lo;
      wr_high = ~hi;
      ecc_used = ~ecc;
      cs_n_pin = 1'b1;
   endtask

   // write-protect pin level, changed just after a clock edge
   task automatic set_wp(input logic lvl);
      @(posedge clk);
      #2 wp_n_pin = lvl;
   endtask
endmodule // status_host_model

// File: verification/tb.sv
// self-checking bench of the status register bank
`timescale 1ns/1ns
module tb;
   localparam int unsigned WC  = 40;
   localparam logic [8:0]  WE  = 9'h001;
   localparam logic [8:0]  WD  = 9'h002;
   localparam logic [8:0]  SW  = 9'h004;
   localparam logic [8:0]  PB  = 9'h020;
   localparam logic [8:0]  AW  = 9'h040;
   localparam logic [8:0]  FRZ = 9'h008;
   localparam logic [8:0]  REL = 9'h010;
   localparam logic [8:0]  RD  = 9'h080;
   localparam logic [8:0]  SR  = 9'h100;
   logic       clk;
   logic       reset;
   logic       cs_n;
   logic       wp_n;
   logic [8:0] stb;
   logic [7:0] wlo;
   logic [7:0] whi;
   logic       ecc;
   logic [7:0] low;
   logic [7:0] high;
   logic       prot;
   logic [1:0] apl;
   logic       enh;
   logic       bnd;
   int         fail_count;
   int         comparisons;
   int         cycles;
   logic [2:0] lv;

   status_host_model host (.clk(clk), .hw_protected(prot), .cs_n_pin(cs_n),
      .wp_n_pin(wp_n), .strobes(stb), .wr_low(wlo), .wr_high(whi), .ecc_used(ecc));

   eeprom_status_register #(.WRITE_CYCLES(WC)) uut (.clk(clk), .reset(reset),
      .wp_n_pin(wp_n), .cs_n_pin(cs_n), .write_enable_cmd(stb[0]),
      .write_disable_cmd(stb[1]), .status_write_cmd(stb[2]), .status_write_low(wlo),
      .status_write_high(whi), .freeze_cmd(stb[3]), .partition_release_cmd(stb[4]),
      .boundary_protect_cmd(stb[5]), .array_write_cmd(stb[6]), .read_done(stb[7]),
      .read_ecc_used(ecc), .soft_reset_cmd(stb[8]), .status_low_byte(low),
      .status_high_byte(high), .hw_protected(prot), .array_protect_level(apl),
      .enhanced_mode(enh), .boundary_locked(bnd));

   initial clk = 1'b0;
   always #25 clk = ~clk;

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      comparisons++;
      if (seen !== exp) begin
         $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
         fail_count++;
      end
   endtask

   task automatic cmd(input logic [8:0] s, input logic [7:0] lo, input logic [7:0] hi);
      host.frame(s, lo, hi, 1'b0);
   endtask

   task automatic wait_ready();
      repeat (WC + 2) @(posedge clk);
      #2;
   endtask

   task automatic final_report();
      $display("comparisons %0d mismatches %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   always @(posedge clk) begin
      cycles++;
      if (cycles == 5000) begin
         fail_count++;
         final_report();
      end
   end

   // ------------------------------------------------------------
   // test sequence
   // ------------------------------------------------------------
   initial begin
      fail_count = 0;
      comparisons = 0;
      cycles = 0;
      reset = 1'b1;
      repeat (6) @(posedge clk);
      #2 reset = 1'b0;
      repeat (3) @(posedge clk);
      #2;
      check(low, 8'h00);
      check(high, 8'h80);
      check({7'h00, enh}, 8'h01);
      cmd(SW, 8'hFF, 8'h7F);
      check(low, 8'h00);
      cmd(WE, 8'h00, 8'h00);
      check(low, 8'h02);
      for (lv = 3'd0; lv < 3'd4; lv++) begin
         cmd(WE, 8'h00, 8'h00);
         cmd(SW, {6'h3F, lv[1:0]} << 2 | 8'h83, 8'h7F);
         check({7'h00, low[0]}, 8'h01);
         check({7'h00, high[0]}, 8'h01);
         host.frame(RD, 8'h00, 8'h00, 1'b1);
         wait_ready();
         check(low, {4'h8, lv[1:0], 2'b00});
         check(high, 8'h00);
         check({6'h00, apl}, {6'h00, lv[1:0]});
         check({7'h00, enh}, 8'h00);
      end
      host.set_wp(1'b0);
      cmd(WE, 8'h00, 8'h00);
      cmd(SW, 8'h00, 8'h00);
      check({7'h00, host.prot_seen}, 8'h01);
      cmd(FRZ, 8'h00, 8'h00);
      check(high, 8'h00);
      wait_ready();
      check(low, 8'h8E);
      host.set_wp(1'b1);
      cmd(SW, 8'h04, 8'h00);
      check({7'h00, host.prot_seen}, 8'h00);
      wait_ready();
      check({6'h00, apl}, 8'h01);
      host.set_wp(1'b0);
      cmd(WE, 8'h00, 8'h00);
      cmd(SW, 8'h08, 8'h00);
      check({7'h00, host.prot_seen}, 8'h00);
      wait_ready();
      check(low, 8'h08);
      cmd(WE, 8'h00, 8'h00);
      cmd(WD, 8'h00, 8'h00);
      check(low, 8'h08);
      cmd(WE, 8'h00, 8'h00);
      cmd(AW, 8'h00, 8'h00);
      check(low, 8'h0B);
      wait_ready();
      check(low, 8'h08);
      cmd(WE, 8'h00, 8'h00);
      cmd(SW, 8'h0C, 8'h80);
      wait_ready();
      check({6'h00, apl}, 8'h00);
      check(high, 8'h80);
      check({7'h00, enh}, 8'h01);
      cmd(WE, 8'h00, 8'h00);
      cmd(SW, 8'h08, 8'h00);
      wait_ready();
      check({6'h00, apl}, 8'h02);
      host.frame(RD, 8'h00, 8'h00, 1'b1);
      check(high, 8'h40);
      host.frame(RD, 8'h00, 8'h00, 1'b0);
      check(high, 8'h00);
      host.frame(RD, 8'h00, 8'h00, 1'b1);
      cmd(SR, 8'h00, 8'h00);
      check(high, 8'h00);
      cmd(WE, 8'h00, 8'h00);
      cmd(REL, 8'h00, 8'h00);
      check(high, 8'h10);
      cmd(FRZ, 8'h00, 8'h00);
      wait_ready();
      check(high, 8'h20);
      check(low, 8'h08);
      cmd(WE, 8'h00, 8'h00);
      cmd(SW, 8'h08, 8'h80);
      wait_ready();
      check(high, 8'h20);
      check({7'h00, enh}, 8'h00);
      cmd(WE, 8'h00, 8'h00);
      cmd(REL, 8'h00, 8'h00);
      cmd(PB, 8'h00, 8'h00);
      wait_ready();
      check(high, 8'h28);
      check({7'h00, bnd}, 8'h01);
      check(low, 8'h08);
      final_report();
   end
endmodule // tb
